// ===== rtl/vbm_monitor.sv
// Error-rate monitor with period control and chainback depth select
`timescale 1ns/10ps
`include "vbm_defines.svh"
// Contract
// - Viterbi decoding offers a full depth of 96 stages and a short one of 48.
// - Bit 0 of the third control register at write address 04H picks the depth.
// - Trellis mode always uses the full depth whatever the select bit says.
// - Decoded bits are re-encoded and each mismatch with delayed code bits is an error.
// - One counter counts input code bits for the period, another counts errors.
// - Measurement only advances on sys_clk edges, gated by sym_valid.
// - The 19-bit error accumulator clears at each period start and sums the period.
// - A write of any data to 18H activates the loaded 24-bit period.
// - When the bit counter completes, the error count goes to a 16-bit buffer.
// - Period completion drives a done output high for exactly two clocks.
// - The buffer reads at 03 and 04H as errors divided by eight plus one.
// - Overflow reads as zero; measurement restarts and overwrites each period.
module vbm_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] proc_addr,
  input wire logic [7:0] proc_wdata,
  input wire logic proc_wr,
  input wire logic proc_rd,
  output logic [7:0] proc_rdata,
  input wire logic trellis_mode,
  input wire logic sym_valid,
  input wire logic [1:0] rx_code,
  input wire logic decoded_output_bits,
  output logic error_period_done,
  output logic chainback_full,
  output logic [6:0] chainback_depth,
  output logic measure_active
);
  logic tm_s1_r;
  logic tm_s2_r;
  logic [7:0] ctrl3_r;
  logic [7:0] per_a_r;
  logic [7:0] per_b_r;
  logic [7:0] per_c_r;
  vbm_pkg::vbm_meas_e state_r;
  vbm_pkg::vbm_period_t per_cnt_r;
  vbm_pkg::vbm_period_t staged;
  logic [18:0] acc_r;
  logic ovf_r;
  logic [19:0] sum;
  vbm_pkg::vbm_result_t result_r;
  vbm_pkg::vbm_result_t result_nxt;
  logic [1:0] done_cnt_r;
  logic [1:0] ring_r [0:127];
  logic [6:0] wptr_r;
  logic [6:0] rd_idx;
  logic [1:0] rx_dly;
  logic [1:0] err_num;
  logic err_vld;
  logic step;
  logic arm_wr;
  logic period_end;
  logic [1:0] add_bits;

  // Mode pin comes from outside, so it is synchronised first
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tm_s1_r <= 1'b0;
      tm_s2_r <= 1'b0;
    end else begin
      tm_s1_r <= trellis_mode;
      tm_s2_r <= tm_s1_r;
    end
  end

  // Processor writes
  assign arm_wr = proc_wr && (proc_addr == `VBM_A_ARM);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl3_r <= `VBM_CTRL3_RST;
    end else if (proc_wr && proc_addr == `VBM_A_CTRL3) begin
      ctrl3_r <= proc_wdata;
    end
  end

  // Staged bytes take effect on the arm write and at each period reload
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      per_a_r <= 8'h00;
      per_b_r <= 8'h00;
      per_c_r <= 8'h00;
    end else if (proc_wr) begin
      if (proc_addr == `VBM_A_PER_A) begin
        per_a_r <= proc_wdata;
      end
      if (proc_addr == `VBM_A_PER_B) begin
        per_b_r <= proc_wdata;
      end
      if (proc_addr == `VBM_A_PER_C) begin
        per_c_r <= proc_wdata;
      end
    end
  end

  assign staged = {per_c_r, per_b_r, per_a_r};

  // Chainback depth; trellis overrides the select bit
  always_comb begin
    chainback_full = tm_s2_r || ctrl3_r[`VBM_CTRL3_DEPTH];
    chainback_depth = chainback_full ? `VBM_DEPTH_FULL : `VBM_DEPTH_SHORT;
  end

  // Received code bits wait in a ring as long as the chainback delay
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_r <= 7'h00;
    end else if (sym_valid) begin
      wptr_r <= wptr_r + 7'h01;
    end
  end

  // Cleared at reset so the first chainback span compares against zeros, not unknowns
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 128; i++) begin
        ring_r[i] <= 2'h0;
      end
    end else if (sym_valid) begin
      ring_r[wptr_r] <= rx_code;
    end
  end

  // Depth change causes a short burst of false errors until the ring refills
  assign rd_idx = wptr_r - chainback_depth;
  assign rx_dly = ring_r[rd_idx];

  vbm_reencoder u_reenc (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bit_valid(sym_valid),
    .dec_bit(decoded_output_bits),
    .rx_pair(rx_dly),
    .err_num_r(err_num),
    .err_vld_r(err_vld)
  );

  // Input code bit counter, first stage
  assign add_bits = (sym_valid && state_r == vbm_pkg::VBM_RUN) ? `VBM_BITS_PER_SYM : 2'h0;

  vbm_prescale u_pre (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(arm_wr),
    .add_bits(add_bits),
    .step(step)
  );

  // Period ends when the counter rolls over to zero
  assign period_end = (state_r == vbm_pkg::VBM_RUN) && step && !arm_wr &&
                      (per_cnt_r == 24'hFFFFFF);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= vbm_pkg::VBM_IDLE;
    end else begin
      case (state_r)
        vbm_pkg::VBM_IDLE: begin
          if (arm_wr) begin
            state_r <= vbm_pkg::VBM_RUN;
          end
        end
        vbm_pkg::VBM_RUN: begin
          state_r <= vbm_pkg::VBM_RUN;
        end
        default: begin
          state_r <= vbm_pkg::VBM_IDLE;
        end
      endcase
    end
  end

  assign measure_active = (state_r == vbm_pkg::VBM_RUN);

  // Period counter reloads itself so measurement restarts unaided
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt_r <= 24'h000000;
    end else if (arm_wr) begin
      per_cnt_r <= staged;
    end else if (period_end) begin
      per_cnt_r <= staged;
    end else if (measure_active && step) begin
      per_cnt_r <= per_cnt_r + 24'h000001;
    end
  end

  // Error accumulator; the extra bit and flag catch overflow
  assign sum = {1'b0, acc_r} + {18'h00000, (err_vld ? err_num : 2'h0)};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= 19'h00000;
      ovf_r <= 1'b0;
    end else if (arm_wr || period_end) begin
      acc_r <= 19'h00000;
      ovf_r <= 1'b0;
    end else if (measure_active) begin
      acc_r <= sum[18:0];
      ovf_r <= ovf_r || sum[19];
    end
  end

  // Result is errors/8 + 1; a carry past 16 bits also reads as zero
  always_comb begin
    if (ovf_r || sum[19]) begin
      result_nxt = 16'h0000;
    end else begin
      result_nxt = sum[18:3] + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= 16'h0000;
    end else if (period_end) begin
      result_r <= result_nxt;
    end
  end

  // Completion pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_cnt_r <= 2'h0;
    end else if (period_end) begin
      done_cnt_r <= `VBM_DONE_CYC;
    end else if (done_cnt_r != 2'h0) begin
      done_cnt_r <= done_cnt_r - 2'h1;
    end
  end

  assign error_period_done = (done_cnt_r != 2'h0);

  // Reads answer one clock after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      proc_rdata <= 8'h00;
    end else if (proc_rd) begin
      case (proc_addr)
        `VBM_A_RES_LO: begin
          proc_rdata <= result_r[7:0];
        end
        `VBM_A_RES_HI: begin
          proc_rdata <= result_r[15:8];
        end
        default: begin
          proc_rdata <= 8'h00;
        end
      endcase
    end
  end

  done_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    period_end |=> error_period_done ##1 error_period_done ##1 !error_period_done)
    else $error("Done pulse is not two clocks long");

  depth_trellis_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    tm_s2_r |-> chainback_depth == 7'h60)
    else $error("Trellis mode not at full depth");

  depth_select_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !tm_s2_r && !ctrl3_r[0] |-> chainback_depth == 7'h30)
    else $error("Short depth not applied");

  acc_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    period_end |=> acc_r == 19'h00000 && !ovf_r)
    else $error("Accumulator not cleared at period start");

  buffer_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    period_end |=> result_r == $past(result_nxt))
    else $error("Buffer did not take the period result");

  ovf_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    period_end && ovf_r |=> result_r == 16'h0000)
    else $error("Overflowed result not zero");

  period_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    measure_active && step && !period_end && !arm_wr
      |=> per_cnt_r == $past(per_cnt_r) + 24'h000001)
    else $error("Period counter did not step");

  arm_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    arm_wr |=> per_cnt_r == $past(staged) && measure_active)
    else $error("Arm write did not load the period");

  idle_still_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !measure_active && !arm_wr |=> $stable(per_cnt_r) && acc_r == 19'h00000)
    else $error("Counting while idle");

  period_end_c: cover property (@(posedge sys_clk) disable iff (!rst_b) period_end);
  overflow_c: cover property (@(posedge sys_clk) disable iff (!rst_b) period_end && ovf_r);
  rearm_c: cover property (@(posedge sys_clk) disable iff (!rst_b) measure_active && arm_wr);
  short_err_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
    measure_active && !chainback_full && err_vld && err_num != 2'h0);
endmodule

// ===== rtl/vbm_defines.svh
// Constants for the error-rate monitor and chainback selection
`ifndef VBM_DEFINES_SVH
`define VBM_DEFINES_SVH
`define VBM_A_CTRL3 8'h04
`define VBM_A_PER_A 8'h0A
`define VBM_A_PER_B 8'h0B
`define VBM_A_PER_C 8'h0C
`define VBM_A_ARM 8'h18
`define VBM_A_RES_LO 8'h03
`define VBM_A_RES_HI 8'h04
`define VBM_CTRL3_RST 8'h01
`define VBM_CTRL3_DEPTH 0
`define VBM_DEPTH_FULL 7'h60
`define VBM_DEPTH_SHORT 7'h30
`define VBM_BITS_PER_STEP 10'h3E8
`define VBM_BITS_PER_SYM 2'h2
`define VBM_DONE_CYC 2'h2
`define VBM_POLY0 7'h79
`define VBM_POLY1 7'h5B
`endif

// ===== rtl/vbm_pkg.sv
// Types shared by the error-rate monitor files
package vbm_pkg;
  typedef enum logic [0:0] {
    VBM_IDLE = 1'b0,
    VBM_RUN = 1'b1
  } vbm_meas_e;
  typedef logic [15:0] vbm_result_t;
  typedef logic [23:0] vbm_period_t;
endpackage

// ===== rtl/vbm_reencoder.sv
// Re-encoder and compare of decoded bits against delayed code bits
`timescale 1ns/10ps
`include "vbm_defines.svh"
module vbm_reencoder (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic bit_valid,
  input wire logic dec_bit,
  input wire logic [1:0] rx_pair,
  output logic [1:0] err_num_r,
  output logic err_vld_r
);
  logic [5:0] sreg_r;
  logic [6:0] taps;
  logic [1:0] enc;
  logic [1:0] diff;

  always_comb begin
    taps = {dec_bit, sreg_r};
    enc[0] = ^(taps & `VBM_POLY0);
    enc[1] = ^(taps & `VBM_POLY1);
    diff = enc ^ rx_pair;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sreg_r <= 6'h00;
    end else if (bit_valid) begin
      sreg_r <= {dec_bit, sreg_r[5:1]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_num_r <= 2'h0;
      err_vld_r <= 1'b0;
    end else begin
      // Each mismatching code bit counts as one error
      err_num_r <= {1'b0, diff[0]} + {1'b0, diff[1]};
      err_vld_r <= bit_valid;
    end
  end

  err_follows_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bit_valid |=> err_vld_r)
    else $error("Compare result missing after a decoded bit");
endmodule

// ===== rtl/vbm_prescale.sv
// Divides the code bit stream into steps of one thousand bits
`timescale 1ns/10ps
`include "vbm_defines.svh"
module vbm_prescale (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic [1:0] add_bits,
  output logic step
);
  logic [9:0] cnt_r;
  logic [10:0] sum;

  always_comb begin
    sum = {1'b0, cnt_r} + {9'h000, add_bits};
    step = !clear && (sum >= {1'b0, `VBM_BITS_PER_STEP});
  end

  // Remainder carries over so no code bit is lost across steps
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 10'h000;
    end else if (clear) begin
      cnt_r <= 10'h000;
    end else if (step) begin
      cnt_r <= 10'(sum - {1'b0, `VBM_BITS_PER_STEP});
    end else begin
      cnt_r <= sum[9:0];
    end
  end

  step_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    step |=> cnt_r < 10'h002)
    else $error("Prescaler remainder wrong after a step");
endmodule

// ===== tb/vbm_proc_model.sv
// Behavioural model of the controlling processor on the register port
`timescale 1ns/10ps
`include "vbm_defines.svh"
module vbm_proc_model (
  input wire logic sys_clk,
  input wire logic [7:0] proc_rdata,
  output logic [7:0] proc_addr,
  output logic [7:0] proc_wdata,
  output logic proc_wr,
  output logic proc_rd
);
  initial begin
    proc_addr = 8'h00;
    proc_wdata = 8'h00;
    proc_wr = 1'b0;
    proc_rd = 1'b0;
  end
  // Released lines show the inverse, so a stale value is never taken as live
  task automatic release_bus();
    proc_wr = 1'b0;
    proc_rd = 1'b0;
    proc_addr = ~proc_addr;
    proc_wdata = ~proc_wdata;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    proc_addr = addr;
    proc_wdata = data;
    proc_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    release_bus();
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    proc_addr = addr;
    proc_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    data = proc_rdata;
    release_bus();
  endtask
  // Period is given in thousands of code bits and loaded as its two's complement
  task automatic program_period(input logic [23:0] steps);
    logic [23:0] neg;
    neg = ~steps + 24'h000001;
    wr(`VBM_A_PER_A, neg[7:0]);
    wr(`VBM_A_PER_B, neg[15:8]);
    wr(`VBM_A_PER_C, neg[23:16]);
    wr(`VBM_A_ARM, 8'h5A);
  endtask
endmodule

// ===== tb/vbm_monitor_tb_top.sv
// Self-checking bench for the error-rate monitor and chainback select
`timescale 1ns/10ps
`include "vbm_defines.svh"
module vbm_monitor_tb_top;
  logic sys_clk, rst_b, proc_wr, proc_rd, trellis_mode, sym_valid, dec_bit;
  logic done, full, active;
  logic [7:0] proc_addr, proc_wdata, proc_rdata, d;
  logic [1:0] rx_code;
  logic [6:0] depth;
  int miscompares, tests_run;

  vbm_monitor u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .proc_addr(proc_addr), .proc_wdata(proc_wdata),
    .proc_wr(proc_wr), .proc_rd(proc_rd), .proc_rdata(proc_rdata),
    .trellis_mode(trellis_mode), .sym_valid(sym_valid), .rx_code(rx_code),
    .decoded_output_bits(dec_bit), .error_period_done(done), .chainback_full(full),
    .chainback_depth(depth), .measure_active(active)
  );
  vbm_proc_model u_proc (
    .sys_clk(sys_clk), .proc_rdata(proc_rdata), .proc_addr(proc_addr),
    .proc_wdata(proc_wdata), .proc_wr(proc_wr), .proc_rd(proc_rd)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // All-zero decoded bits keep the re-encoder at 00, so only rx bursts make errors
  task automatic send(input int n, input int lo, input int hi);
    for (int i = 0; i < n; i++) begin
      sym_valid = 1'b1;
      dec_bit = 1'b0;
      rx_code = (i >= lo && i < hi) ? 2'h3 : 2'h0;
      @(posedge sys_clk);
      #1;
      if (i < n - 1) chk(16'(done), 16'h0000);
    end
    sym_valid = 1'b0;
    dec_bit = 1'b1;
    rx_code = 2'h2;
  endtask

  task automatic end_period();
    chk(16'(done), 16'h0001);
    @(posedge sys_clk);
    #1;
    chk(16'(done), 16'h0001);
    @(posedge sys_clk);
    #1;
    chk(16'(done), 16'h0000);
  endtask

  task automatic rd_res(input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    u_proc.rd(`VBM_A_RES_LO, lo);
    u_proc.rd(`VBM_A_RES_HI, hi);
    chk({hi, lo}, exp);
  endtask

  initial begin
    rst_b = 1'b0;
    trellis_mode = 1'b0;
    sym_valid = 1'b0;
    dec_bit = 1'b1;
    rx_code = 2'h2;
    miscompares = 0;
    tests_run = 0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    chk(16'(full), 16'h0001);
    chk(16'(depth), 16'h0060);
    chk(16'(active), 16'h0000);
    u_proc.rd(8'h55, d);
    chk(16'(d), 16'h0000);
    u_proc.rd(`VBM_A_PER_A, d);
    chk(16'(d), 16'h0000);
    rd_res(16'h0000);
    u_proc.wr(`VBM_A_CTRL3, 8'h00);
    chk(16'(full), 16'h0000);
    chk(16'(depth), 16'h0030);
    trellis_mode = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(16'(full), 16'h0001);
    chk(16'(depth), 16'h0060);
    trellis_mode = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(16'(depth), 16'h0030);
    u_proc.wr(`VBM_A_CTRL3, 8'h01);
    u_proc.program_period(24'h000002);
    chk(16'(active), 16'h0001);
    // Two steps: no done after 500 symbols, done after 1000
    send(1000, 0, 0);
    end_period();
    // Re-arming mid-run restarts with a one-step period
    u_proc.program_period(24'h000001);
    send(500, 0, 0);
    end_period();
    rd_res(16'h0001);
    // 200 errors in mid period: 200/8 + 1
    send(500, 100, 200);
    end_period();
    rd_res(16'h001A);
    // Short depth pulls a late burst of 40 errors into this period
    u_proc.wr(`VBM_A_CTRL3, 8'h00);
    send(500, 420, 440);
    end_period();
    rd_res(16'h0006);
    wrap_up();
  end

  initial begin
    #300000;
    miscompares++;
    wrap_up();
  end
endmodule
